//--- ext_bus_ctrl.sv
// External memory bus controller: selects, strobes, wait states, hold
`timescale 1ns/1ps

`include "ext_bus_regs.svh"

// Overview of operation
// - One space select low, only during access
// - Float input low floats all control outputs
// - Memory strobe low only for data/program access
// - Peripheral strobe low only for I/O access
// - Direction high, low only during writes
// - Ready low: wait a cycle, sample again
// - Ready used only with two+ wait states
// - Ready sampled only after software wait states
// - Hold acknowledged: bus lines float
// - Grant acknowledge low while in hold
// - Marker low at first of two+ software wait states
// - Marker high at last software wait state
// - Marker fed to ready adds one wait
// - Fetch flag low during instruction fetch address
module ext_bus_ctrl (
   // Clock and reset
   input  wire logic                     sys_clk_in,
   input  wire logic                     reset_n_in,
   // Core request port
   input  wire logic                     req_valid_in,
   input  wire ext_bus_pkg::bus_req_t    req_in,
   output logic                          req_ready_out,
   output logic                          done_out,
   // Pins from outside
   input  wire logic                     ready_in,
   input  wire logic                     hold_req_n_in,
   input  wire logic                     output_float_n_in,
   // Bus pins that float in hold
   output ext_bus_pkg::bus_ctrl_t        bus_ctrl_out,
   output logic [`ADDR_WIDTH-1:0]        addr_out,
   output logic                          bus_oe_out,
   // Status pins
   output ext_bus_pkg::bus_status_t      bus_status_out,
   output logic                          status_oe_out
);

   import ext_bus_pkg::*;

   // Access sequencer states
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ACCESS,
      ST_WAIT,
      ST_READY,
      ST_HOLD
   } state_t;

   // Pin synchronisers
   logic                   ready_s1_reg;    // First stage, ready
   logic                   ready_s2_reg;    // Synchronised ready
   logic                   hold_s1_reg;     // First stage, hold request
   logic                   hold_n_s2_reg;   // Synchronised hold request
   logic                   float_s1_reg;    // First stage, float input
   logic                   float_n_s2_reg;  // Synchronised float input

   // Sequencer state
   state_t                 state_reg;       // Current state
   state_t                 state_next;      // Next state
   bus_req_t               cur_reg;         // Access in progress
   bus_req_t               cur_next;        // Next access
   logic                   ws_load;         // Load the wait counter
   logic                   ws_dec;          // Count one wait state
   logic [`WS_WIDTH-1:0]   ws_count;        // Wait states left
   logic [`WS_WIDTH-1:0]   ws_count_next;   // Wait states left next cycle
   logic                   finish;          // Last bus cycle of an access

   // Output registers
   bus_ctrl_t              ctrl_reg;        // Bus control pins
   bus_ctrl_t              ctrl_next;
   bus_status_t            status_reg;      // Status pins
   bus_status_t            status_next;
   logic [`ADDR_WIDTH-1:0] addr_reg;        // Address pins
   logic [`ADDR_WIDTH-1:0] addr_next;
   logic                   bus_oe_reg;      // Drive bus control pins
   logic                   bus_oe_next;
   logic                   status_oe_reg;   // Drive status pins
   logic                   status_oe_next;
   logic                   req_ready_reg;   // Sequencer free
   logic                   req_ready_next;
   logic                   done_reg;        // Access completed
   logic                   done_next;

   // True while a state drives an access on the bus
   function automatic logic busy_state(input state_t s);
      busy_state = (s == ST_ACCESS) || (s == ST_WAIT) || (s == ST_READY);
   endfunction

   // Wait-state counter
   wait_state_counter u_ws (
      .sys_clk_in     (sys_clk_in),
      .reset_n_in     (reset_n_in),
      .load_in        (ws_load),
      .load_value_in  (cur_next.wait_states),
      .dec_in         (ws_dec),
      .count_out      (ws_count),
      .count_next_out (ws_count_next)
   );

   // Two flip-flops on every pin input; only the second stage is read
   always_ff @(posedge sys_clk_in) begin
      if (!reset_n_in) begin
         ready_s1_reg   <= 1'h0;
         ready_s2_reg   <= 1'h0;
         hold_s1_reg    <= 1'h1;
         hold_n_s2_reg  <= 1'h1;
         float_s1_reg   <= 1'h1;
         float_n_s2_reg <= 1'h1;
      end else begin
         ready_s1_reg   <= ready_in;
         ready_s2_reg   <= ready_s1_reg;
         hold_s1_reg    <= hold_req_n_in;
         hold_n_s2_reg  <= hold_s1_reg;
         float_s1_reg   <= output_float_n_in;
         float_n_s2_reg <= float_s1_reg;
      end
   end

   // Sequencer next state
   always_comb begin
      state_next = state_reg;
      cur_next   = cur_reg;
      ws_load    = 1'h0;
      ws_dec     = 1'h0;
      finish     = 1'h0;
      case (state_reg)
         // Hold wins over a new access, so grants fall between accesses
         ST_IDLE: begin
            if (!hold_n_s2_reg) begin
               state_next = ST_HOLD;
            end else if (req_valid_in) begin
               state_next = ST_ACCESS;
               cur_next   = req_in;
               ws_load    = 1'h1;
            end
         end
         // First bus cycle; no wait states ends the access here
         ST_ACCESS: begin
            if (ws_count == `WS_NONE) begin
               finish     = 1'h1;
               state_next = ST_IDLE;
            end else begin
               state_next = ST_WAIT;
            end
         end
         // Software wait states; ready is not looked at here
         ST_WAIT: begin
            ws_dec = 1'h1;
            if (ws_count == `WS_LAST) begin
               if (cur_reg.wait_states >= `WS_READY_MIN) begin
                  state_next = ST_READY;
               end else begin
                  finish     = 1'h1;
                  state_next = ST_IDLE;
               end
            end
         end
         // Sample ready once per cycle until found high
         ST_READY: begin
            if (ready_s2_reg) begin
               finish     = 1'h1;
               state_next = ST_IDLE;
            end else begin
               state_next = ST_READY;
            end
         end
         // Bus given away until the request is released
         ST_HOLD: begin
            if (hold_n_s2_reg) begin
               state_next = ST_IDLE;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   // Sequencer registers
   always_ff @(posedge sys_clk_in) begin
      if (!reset_n_in) begin
         state_reg <= ST_IDLE;
         cur_reg   <= '0;
      end else begin
         state_reg <= state_next;
         cur_reg   <= cur_next;
      end
   end

   // Pin values follow the next state so pins line up with the state
   always_comb begin
      ctrl_next      = '1;
      status_next    = '1;
      addr_next      = addr_reg;
      // Selects and strobes only while an access is on the bus
      if (busy_state(state_next)) begin
         addr_next = cur_next.addr;
         case (cur_next.space)
            SPACE_DATA: begin
               ctrl_next.data_space_select_n    = 1'h0;
               ctrl_next.memory_access_strobe_n = 1'h0;
            end
            SPACE_PROGRAM: begin
               ctrl_next.program_space_select_n = 1'h0;
               ctrl_next.memory_access_strobe_n = 1'h0;
            end
            SPACE_IO: begin
               ctrl_next.io_space_select_n          = 1'h0;
               ctrl_next.peripheral_access_strobe_n = 1'h0;
            end
            default: begin
               ctrl_next = '1;
            end
         endcase
         ctrl_next.read_write_n               = !cur_next.write;
         status_next.fetch_address_flag_n     = !cur_next.fetch;
      end
      // Marker low from the first wait state up to the last one
      if ((state_next == ST_WAIT) && (ws_count_next > `WS_LAST) &&
          (cur_next.wait_states >= `WS_READY_MIN)) begin
         status_next.wait_state_marker_n = 1'h0;
      end
      status_next.bus_grant_ack_n = !(state_next == ST_HOLD);
      bus_oe_next    = float_n_s2_reg && (state_next != ST_HOLD);
      status_oe_next = float_n_s2_reg;
      req_ready_next = (state_next == ST_IDLE);
      done_next      = finish;
   end

   // Output registers
   always_ff @(posedge sys_clk_in) begin
      if (!reset_n_in) begin
         ctrl_reg      <= '1;
         status_reg    <= '1;
         addr_reg      <= `ADDR_RESET;
         bus_oe_reg    <= 1'h0;
         status_oe_reg <= 1'h0;
         req_ready_reg <= 1'h0;
         done_reg      <= 1'h0;
      end else begin
         ctrl_reg      <= ctrl_next;
         status_reg    <= status_next;
         addr_reg      <= addr_next;
         bus_oe_reg    <= bus_oe_next;
         status_oe_reg <= status_oe_next;
         req_ready_reg <= req_ready_next;
         done_reg      <= done_next;
      end
   end

   assign bus_ctrl_out   = ctrl_reg;
   assign bus_status_out = status_reg;
   assign addr_out       = addr_reg;
   assign bus_oe_out     = bus_oe_reg;
   assign status_oe_out  = status_oe_reg;
   assign req_ready_out  = req_ready_reg;
   assign done_out       = done_reg;

   // Checks on the pins against the sequencer
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (!reset_n_in);

   AST_ONE_SELECT: assert property (
      $onehot0({!ctrl_reg.data_space_select_n, !ctrl_reg.program_space_select_n,
                !ctrl_reg.io_space_select_n}) && (busy_state(state_reg) ||
      (ctrl_reg.data_space_select_n && ctrl_reg.program_space_select_n && ctrl_reg.io_space_select_n)))
      else $error("Space selects wrong for the sequencer state");
   AST_FLOAT_ALL: assert property (!float_n_s2_reg |=> !bus_oe_reg && !status_oe_reg)
      else $error("Outputs still driven with float input low");
   AST_MEM_STROBE: assert property (!ctrl_reg.memory_access_strobe_n |->
      busy_state(state_reg) && (cur_reg.space != SPACE_IO))
      else $error("Memory strobe low outside a memory access");
   AST_IO_STROBE: assert property (!ctrl_reg.peripheral_access_strobe_n |->
      !ctrl_reg.io_space_select_n && ctrl_reg.memory_access_strobe_n)
      else $error("Peripheral strobe low outside an I/O access");
   AST_WRITE_DIR: assert property (!ctrl_reg.read_write_n |-> busy_state(state_reg) && cur_reg.write)
      else $error("Direction low outside a write");
   AST_READY_STALL: assert property ((state_reg == ST_READY) && !ready_s2_reg |=> state_reg == ST_READY)
      else $error("Access ended with ready low");
   AST_READY_IGNORED: assert property ((state_reg == ST_WAIT) && (ws_count == `WS_LAST) &&
      (cur_reg.wait_states < `WS_READY_MIN) |=> (state_reg == ST_IDLE) && done_reg)
      else $error("Short wait access did not end on its last wait state");
   AST_NO_EARLY_READY: assert property ((state_reg == ST_WAIT) && (ws_count != `WS_LAST)
      |=> state_reg == ST_WAIT)
      else $error("Wait states cut short");
   AST_HOLD_FLOAT: assert property (!status_reg.bus_grant_ack_n |-> !bus_oe_reg &&
      (state_reg == ST_HOLD))
      else $error("Grant acknowledge low with bus driven");
   AST_MARKER_LOW: assert property ((state_reg == ST_WAIT) && (ws_count > `WS_LAST) |->
      !status_reg.wait_state_marker_n)
      else $error("Marker high in an early wait state");
   AST_MARKER_HIGH: assert property (!busy_state(state_reg) || (ws_count == `WS_LAST) |->
      status_reg.wait_state_marker_n)
      else $error("Marker low in the last wait state");
   AST_FETCH_FLAG: assert property (!status_reg.fetch_address_flag_n |->
      busy_state(state_reg) && cur_reg.fetch)
      else $error("Fetch flag low without a fetch");
   AST_HOLD_BETWEEN: assert property ((state_reg == ST_ACCESS) |=> (state_reg != ST_HOLD))
      else $error("Hold granted inside an access");

   COV_HOLD: cover property ((state_reg == ST_IDLE) ##1 (state_reg == ST_HOLD));
   COV_READY_STALL: cover property ((state_reg == ST_READY) ##1 (state_reg == ST_READY) ##1 done_reg);
   COV_IO_WRITE: cover property (!ctrl_reg.peripheral_access_strobe_n && !ctrl_reg.read_write_n);
   COV_FETCH: cover property (!status_reg.fetch_address_flag_n && !ctrl_reg.program_space_select_n);

endmodule

//--- ext_bus_regs.svh
// Constants for the external memory bus controller
`ifndef EXT_BUS_REGS_SVH
`define EXT_BUS_REGS_SVH

// Width of the software wait-state count
`define WS_WIDTH        3
// Least wait-state count that turns on ready sampling and the marker
`define WS_READY_MIN    3'h2
// Wait-state count at which the current wait state is the last one
`define WS_LAST         3'h1
// Empty wait-state count
`define WS_NONE         3'h0
// External address width
`define ADDR_WIDTH      16
// Reset value of the address pins
`define ADDR_RESET      16'h0000
// Idle level of every active-low bus control pin
`define CTRL_IDLE       1'h1

`endif

//--- ext_bus_pkg.sv
// Types shared by the external memory bus controller
package ext_bus_pkg;

`include "ext_bus_regs.svh"

   // External space an access goes to
   typedef enum logic [1:0] {
      SPACE_DATA,
      SPACE_PROGRAM,
      SPACE_IO
   } space_t;

   // One access request from the core
   typedef struct packed {
      space_t                  space;        // Target space
      logic                    write;        // High for a write
      logic                    fetch;        // High for an instruction fetch
      logic [`WS_WIDTH-1:0]    wait_states;  // Software wait states
      logic [`ADDR_WIDTH-1:0]  addr;         // Access address
   } bus_req_t;

   // Bus control pins that float in hold mode
   typedef struct packed {
      logic data_space_select_n;
      logic program_space_select_n;
      logic io_space_select_n;
      logic memory_access_strobe_n;
      logic peripheral_access_strobe_n;
      logic read_write_n;
   } bus_ctrl_t;

   // Status pins that float only on the float input
   typedef struct packed {
      logic bus_grant_ack_n;
      logic wait_state_marker_n;
      logic fetch_address_flag_n;
   } bus_status_t;

endpackage

//--- wait_state_counter.sv
// Down counter for the software wait states of one access
`timescale 1ns/1ps

`include "ext_bus_regs.svh"

module wait_state_counter (
   // Clock and reset
   input  wire logic                 sys_clk_in,
   input  wire logic                 reset_n_in,
   // Control
   input  wire logic                 load_in,
   input  wire logic [`WS_WIDTH-1:0] load_value_in,
   input  wire logic                 dec_in,
   // Count
   output logic      [`WS_WIDTH-1:0] count_out,
   output logic      [`WS_WIDTH-1:0] count_next_out
);

   logic [`WS_WIDTH-1:0] count_reg;   // Wait states still to run
   logic [`WS_WIDTH-1:0] count_next;  // Next count

   // Load wins over decrement; never wraps below zero
   always_comb begin
      count_next = count_reg;
      if (load_in) begin
         count_next = load_value_in;
      end else if (dec_in && (count_reg != `WS_NONE)) begin
         count_next = count_reg - `WS_LAST;
      end
   end

   // Register the count
   always_ff @(posedge sys_clk_in) begin
      if (!reset_n_in) begin
         count_reg <= `WS_NONE;
      end else begin
         count_reg <= count_next;
      end
   end

   assign count_out      = count_reg;
   assign count_next_out = count_next;

endmodule

//--- ext_side_model.sv
// Far-side model: memory ready source and alternate bus master
`timescale 1ns/1ps
module ext_side_model (
   // Clock and reset
   input  wire logic       sys_clk_in,
   input  wire logic       reset_n_in,
   // Bus view and test controls
   input  wire logic       access_in,
   input  wire logic       marker_n_in,
   input  wire logic       marker_loop_in,
   input  wire logic [3:0] ready_delay_in,
   input  wire logic       hold_go_in,
   // Pins toward the block
   output logic            ready_out,
   output logic            hold_req_n_out
);
   logic [3:0] wait_reg;   // Cycles of the current access so far
   logic [3:0] wait_next;  // Next cycle count

   // Count access cycles, saturating so ready stays high once raised
   always_comb begin
      wait_next = 4'h0;
      if (access_in && wait_reg != 4'hF) begin
         wait_next = wait_reg + 4'h1;
      end else if (access_in) begin
         wait_next = wait_reg;
      end
   end

   // Register the count
   always_ff @(posedge sys_clk_in) begin
      wait_reg <= reset_n_in ? wait_next : 4'h0;
   end

   // Ready high once prepared, low to stretch; or the marker looped back
   assign ready_out = marker_loop_in ? marker_n_in : (access_in && wait_reg >= ready_delay_in);
   // Hold request kept low for as long as the bus is wanted
   assign hold_req_n_out = !hold_go_in;
endmodule

//--- tb_top.sv
// Self-checking testbench of the external memory bus controller
`timescale 1ns/1ps
module tb_top;
   import ext_bus_pkg::*;
   logic        sys_clk, reset_n, req_valid, req_ready, done, ready, hold_req_n, float_n;
   logic        bus_oe, status_oe, access, marker_loop, hold_go, inflight, prev_rdy;
   logic [3:0]  ready_delay;
   logic [15:0] addr;
   bus_req_t    req, cur;
   bus_ctrl_t   ctrl, exp_ctrl;
   bus_status_t stat;
   int          n_errors, checks_done, cnt, mk;
   int          q_min[$];
   int          q_max[$];

   // Design and far-side model
   ext_bus_ctrl i_ext_bus_ctrl (.sys_clk_in(sys_clk), .reset_n_in(reset_n), .req_valid_in(req_valid),
      .req_in(req), .req_ready_out(req_ready), .done_out(done), .ready_in(ready), .hold_req_n_in(hold_req_n),
      .output_float_n_in(float_n), .bus_ctrl_out(ctrl), .addr_out(addr), .bus_oe_out(bus_oe),
      .bus_status_out(stat), .status_oe_out(status_oe));
   ext_side_model i_ext_side_model (.sys_clk_in(sys_clk), .reset_n_in(reset_n), .access_in(access),
      .marker_n_in(stat.wait_state_marker_n), .marker_loop_in(marker_loop), .ready_delay_in(ready_delay),
      .hold_go_in(hold_go), .ready_out(ready), .hold_req_n_out(hold_req_n));
   assign access = bus_oe && !(ctrl.data_space_select_n && ctrl.program_space_select_n && ctrl.io_space_select_n);

   // Clock generator
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   // One comparison
   task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
      end
   endtask

   // Verdict and end of run
   task automatic wrap_up();
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Least access length for a wait-state count with prompt ready
   function automatic int lat(int n);
      return (n == 0) ? 2 : (n == 1) ? 3 : n + 3;
   endfunction

   // Offer one access, note its expected length, hold it until taken
   task automatic send(int sp, logic wr, logic fe, int n, int mn, int mx);
      logic r;
      int   i;
      // Let one edge pass so valid is never lowered and raised in one time step
      if (req_valid) @(posedge sys_clk);
      req       <= '{space_t'(sp), wr, fe, 3'(n), 16'($urandom)};
      req_valid <= 1'b1;
      q_min.push_back(mn);
      q_max.push_back(mx);
      for (i = 0; i < 200; i++) begin
         @(negedge sys_clk);
         r = req_ready;
         @(posedge sys_clk);
         #1;
         if (r && !req_ready) break;
      end
      @(posedge sys_clk);
      req_valid <= 1'b0;
   endtask

   // Wait until the sequencer is idle again
   task automatic settle();
      int i;
      for (i = 0; i < 100 && (inflight || req_valid); i++) @(posedge sys_clk);
      @(posedge sys_clk);
      // Look at the pins once they have settled after the edge
      #1;
   endtask

   // Output watcher: per-cycle pin checks, and length check against the oldest note
   always @(negedge sys_clk) begin
      if (reset_n) begin
         // Entering hold also drops ready; only a drop with the grant high is an access
         if (prev_rdy && !req_ready && (stat.bus_grant_ack_n === 1'b1)) begin
            inflight = 1'b1;
            cnt      = 0;
            mk       = 0;
            cur      = req;
         end
         exp_ctrl = {1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
         if (inflight && !done) begin
            cnt++;
            mk += (stat.wait_state_marker_n === 1'b0);
            exp_ctrl = {cur.space != SPACE_DATA, cur.space != SPACE_PROGRAM, cur.space != SPACE_IO,
                        cur.space == SPACE_IO, cur.space != SPACE_IO, !cur.write};
            chk("addr", cur.addr, addr);
            chk("bus_oe", 1, bus_oe);
            chk("fetch_flag", !cur.fetch, stat.fetch_address_flag_n);
         end
         if (bus_oe) chk("ctrl", exp_ctrl, ctrl);
         if (!inflight && status_oe) chk("fetch_idle", 1, stat.fetch_address_flag_n);
         if (!inflight && status_oe) chk("marker_idle", 1, stat.wait_state_marker_n);
         if (stat.bus_grant_ack_n === 1'b0) chk("oe_in_hold", 0, bus_oe);
         if (done === 1'b1) begin
            // Length runs from the take edge to the cycle in which done stands
            cnt++;
            chk("marker_lows", (cur.wait_states >= 2) ? cur.wait_states - 1 : 0, mk);
            checks_done++;
            if (!inflight || q_min.size() == 0 || cnt < q_min[0] || cnt > q_max[0]) begin
               n_errors++;
               $display("[FAIL] access_length expected %0d..%0d seen %0d", q_min[0], q_max[0], cnt);
            end
            if (q_min.size() > 0) void'(q_min.pop_front());
            if (q_max.size() > 0) void'(q_max.pop_front());
            inflight = 1'b0;
         end
      end
      prev_rdy = req_ready;
   end

   // Watchdog
   initial begin
      #(20000 * 100);
      n_errors++;
      wrap_up();
   end

   // Main sequence
   initial begin
      int i;
      void'($urandom(25346));
      reset_n = 1'b0; req_valid = 1'b0; req = '0; float_n = 1'b1; marker_loop = 1'b0;
      ready_delay = 4'h0; hold_go = 1'b0; inflight = 1'b0; prev_rdy = 1'b0;
      n_errors = 0; checks_done = 0;
      repeat (4) @(posedge sys_clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
      // Every space, both directions, every wait-state count, back to back
      for (i = 0; i < 16; i++) send(i % 3, (i / 3) % 2, $urandom % 2, i % 8, lat(i % 8), lat(i % 8));
      settle();
      // Slow device stretches the access
      for (i = 2; i < 5; i++) begin
         ready_delay <= 4'(i + 4);
         send($urandom % 3, $urandom % 2, 0, i, i + 4, 2 * i + 10);
         settle();
      end
      // Ready stuck low is ignored below two wait states
      ready_delay <= 4'hF;
      send(0, 0, 0, 0, 2, 2);
      send(2, 1, 0, 1, 3, 3);
      settle();
      // Marker looped to ready adds exactly one wait
      ready_delay <= 4'h0;
      marker_loop <= 1'b1;
      send(1, 0, 1, 2, 6, 6);
      send(0, 1, 0, 5, 9, 9);
      settle();
      marker_loop <= 1'b0;
      // Hold raised mid-access is granted only after the access
      fork
         send(0, 1, 0, 6, 9, 9);
         begin
            repeat (3) @(posedge sys_clk);
            hold_go <= 1'b1;
         end
      join
      settle();
      chk("hold_ack", 0, stat.bus_grant_ack_n);
      chk("hold_oe", 0, bus_oe);
      // Request during hold waits for release
      fork
         send(2, 0, 0, 2, 5, 5);
         begin
            repeat (6) @(posedge sys_clk);
            chk("taken_in_hold", 0, inflight);
            hold_go <= 1'b0;
         end
      join
      settle();
      chk("ack_released", 1, stat.bus_grant_ack_n);
      // Float input releases every output
      float_n <= 1'b0;
      repeat (5) @(posedge sys_clk);
      #1;
      chk("float_bus_oe", 0, bus_oe);
      chk("float_status_oe", 0, status_oe);
      float_n <= 1'b1;
      repeat (5) @(posedge sys_clk);
      #1;
      chk("unfloat_oe", 2'b11, {bus_oe, status_oe});
      chk("notes_left", 0, q_min.size());
      wrap_up();
   end
endmodule
